// *** hw/barc_regs.vh ***
// timing constants and register map of the burst and restart controller
`ifndef BARC_REGS_VH
`define BARC_REGS_VH

// clock rate in kHz and basic tick
`define BARC_CLK_KHZ 125000
`define BARC_TICK_NS 1000
`define BARC_TICK_CYC 125
`define BARC_TICK_W 7
`define BARC_NS_PER_US 1000

// blanking times in microseconds, the figures as given
`define BARC_BURST_BLANK_US 20000
`define BARC_OVL_BLANK_US 20000
`define BARC_SPIKE_US 30
`define BARC_OVP_HI_US 150
`define BARC_UV_US 10030
`define BARC_RESTART_MASK_US 1000
`define BARC_TMR_W 15

// wishbone register byte addresses
`define BARC_ADDR_W 4
`define BARC_REG_CTRL 4'h0
`define BARC_REG_STATUS 4'h4
`define BARC_REG_CAUSE 4'h8

// control register fields
`define BARC_CTRL_BURST_EN 0
`define BARC_CTRL_RESTART_EN 1
`define BARC_CTRL_RST 2'h3

// status register fields
`define BARC_ST_BURST 0
`define BARC_ST_BIAS 1
`define BARC_ST_RLIM 2
`define BARC_ST_RESTART 3
`define BARC_ST_STARTUP 4
`define BARC_ST_SOFT 5
`define BARC_ST_CLAMP 6
`define BARC_ST_GATE 7

// fault cause bits
`define BARC_NCAUSE 6
`define BARC_C_OVP_SS 0
`define BARC_C_OVP_HI 1
`define BARC_C_OTP 2
`define BARC_C_OVL 3
`define BARC_C_UV 4
`define BARC_C_EXT 5

// restart states
`define BARC_ST_W 2
`define BARC_S_RUN 2'h0
`define BARC_S_OFF 2'h1
`define BARC_S_CHARGE 2'h2
`define BARC_S_SOFT 2'h3

`endif

// *** hw/barc_qual_timer.v ***
// qualification timer: counts ticks while a condition holds
`timescale 1ns/1ps
`default_nettype none
module barc_qual_timer #(
    parameter [14:0] LIMIT = 15'h0001
) (
    input wire core_clk_in,
    input wire rst_in,
    input wire tick_in,
    input wire cond_in,
    output reg done_out
);
    reg [14:0] cnt_ff;
    // count while the condition holds, drop to zero when it falls
    always @(posedge core_clk_in) begin
        if (rst_in || !cond_in) begin
            cnt_ff <= 15'h0000;
            done_out <= 1'b0;
        end else if (tick_in && !done_out) begin
            if (cnt_ff == LIMIT - 15'h0001) begin
                done_out <= 1'b1;
            end
            cnt_ff <= cnt_ff + 15'h0001;
        end
    end
endmodule
`default_nettype wire

// *** hw/barc_core.v ***
// burst mode and auto restart control unit with wishbone registers
//
// The register offsets and the Wishbone interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "barc_regs.vh"
module barc_core (
    input wire core_clk_in,
    input wire rst_in,
    input wire fb_below_1v35_in,
    input wire fb_above_3v5_in,
    input wire fb_below_3v0_in,
    input wire fb_above_4v0_in,
    input wire vcc_above_20v5_in,
    input wire vcc_above_25v5_in,
    input wire vcc_below_10v5_in,
    input wire vcc_above_on_in,
    input wire over_temp_in,
    input wire pin_above_4v0_in,
    input wire pin_below_0v33_in,
    input wire soft_start_done_in,
    input wire [31:0] wb_adr_i,
    input wire [31:0] wb_dat_i,
    input wire [3:0] wb_sel_i,
    input wire wb_we_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    output reg bias_en_out,
    output reg reduced_limit_out,
    output reg gate_en_out,
    output reg pin_clamp_out,
    output reg startup_cell_out,
    output reg soft_start_out
);
    ////////////////////////////////////////////////////////////////////
    // timing derived from the clock
    // counts worked out as integers, then cut to the timer width on purpose
    localparam integer N_BURST = `BARC_BURST_BLANK_US * `BARC_NS_PER_US / `BARC_TICK_NS;
    localparam integer N_OVL = `BARC_OVL_BLANK_US * `BARC_NS_PER_US / `BARC_TICK_NS;
    localparam integer N_SPIKE = `BARC_SPIKE_US * `BARC_NS_PER_US / `BARC_TICK_NS;
    localparam integer N_OVP_HI = `BARC_OVP_HI_US * `BARC_NS_PER_US / `BARC_TICK_NS;
    localparam integer N_UV = `BARC_UV_US * `BARC_NS_PER_US / `BARC_TICK_NS;
    localparam integer N_MASK = `BARC_RESTART_MASK_US * `BARC_NS_PER_US / `BARC_TICK_NS;
    localparam integer N_TICK_LAST = `BARC_TICK_CYC - 1;
    localparam [`BARC_TMR_W-1:0] T_BURST = N_BURST[`BARC_TMR_W-1:0];
    localparam [`BARC_TMR_W-1:0] T_OVL = N_OVL[`BARC_TMR_W-1:0];
    localparam [`BARC_TMR_W-1:0] T_SPIKE = N_SPIKE[`BARC_TMR_W-1:0];
    localparam [`BARC_TMR_W-1:0] T_OVP_HI = N_OVP_HI[`BARC_TMR_W-1:0];
    localparam [`BARC_TMR_W-1:0] T_UV = N_UV[`BARC_TMR_W-1:0];
    localparam [`BARC_TMR_W-1:0] T_MASK = N_MASK[`BARC_TMR_W-1:0];
    localparam [`BARC_TICK_W-1:0] TICK_LAST = N_TICK_LAST[`BARC_TICK_W-1:0];

    ////////////////////////////////////////////////////////////////////
    // comparator synchronisers, two flops each
    localparam NSYNC = 13;
    wire [NSYNC-1:0] raw_in;
    reg [NSYNC-1:0] sync1_ff;
    reg [NSYNC-1:0] sync2_ff;
    assign raw_in = {soft_start_done_in, pin_below_0v33_in, pin_above_4v0_in,
        over_temp_in, vcc_above_on_in, vcc_below_10v5_in, vcc_above_25v5_in,
        vcc_above_20v5_in, fb_above_4v0_in, fb_below_3v0_in, fb_above_3v5_in,
        fb_below_1v35_in, 1'b0};
    genvar gi;
    generate
        for (gi = 0; gi < NSYNC; gi = gi + 1) begin : g_sync
            always @(posedge core_clk_in) begin
                if (rst_in) begin
                    sync1_ff[gi] <= 1'b0;
                    sync2_ff[gi] <= 1'b0;
                end else begin
                    sync1_ff[gi] <= raw_in[gi];
                    sync2_ff[gi] <= sync1_ff[gi];
                end
            end
        end
    endgenerate
    wire fb_low = sync2_ff[1];
    wire fb_wake = sync2_ff[2];
    wire fb_sleep = sync2_ff[3];
    wire fb_high = sync2_ff[4];
    wire vcc_ov_ss = sync2_ff[5];
    wire vcc_ov_hi = sync2_ff[6];
    wire vcc_uv = sync2_ff[7];
    wire vcc_on = sync2_ff[8];
    wire otp = sync2_ff[9];
    wire pin_high = sync2_ff[10];
    wire pin_low = sync2_ff[11];
    wire ss_done = sync2_ff[12];

    ////////////////////////////////////////////////////////////////////
    // one microsecond tick
    reg [`BARC_TICK_W-1:0] div_ff;
    reg tick_ff;
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            div_ff <= {`BARC_TICK_W{1'b0}};
            tick_ff <= 1'b0;
        end else begin
            tick_ff <= (div_ff == TICK_LAST);
            div_ff <= (div_ff == TICK_LAST) ? {`BARC_TICK_W{1'b0}} :
                div_ff + {{(`BARC_TICK_W-1){1'b0}}, 1'b1};
        end
    end

    ////////////////////////////////////////////////////////////////////
    // registers and restart state
    reg [1:0] ctrl_ff;
    reg burst_ff;
    reg [`BARC_ST_W-1:0] state_ff;
    reg [`BARC_NCAUSE-1:0] cause_ff;
    reg clamp_rel_ff;
    wire running = (state_ff == `BARC_S_RUN) || (state_ff == `BARC_S_SOFT);
    wire in_soft = (state_ff == `BARC_S_SOFT);

    ////////////////////////////////////////////////////////////////////
    // qualification timers
    wire burst_q;
    wire ovl_q;
    wire ovp_ss_q;
    wire ovp_hi_q;
    wire otp_q;
    wire ovl_pin_q;
    wire uv_q;
    wire ext_q;
    wire mask_q;
    // burst entry blanking, idle at zero while feedback is normal
    barc_qual_timer #(.LIMIT(T_BURST)) u_burst (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff),
        .cond_in(fb_low && !burst_ff && running && ctrl_ff[`BARC_CTRL_BURST_EN]),
        .done_out(burst_q));
    // overload blanking outside burst
    barc_qual_timer #(.LIMIT(T_OVL)) u_ovl (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff), .cond_in(fb_high && !burst_ff && running),
        .done_out(ovl_q));
    barc_qual_timer #(.LIMIT(T_SPIKE)) u_ovpss (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff), .cond_in(vcc_ov_ss && fb_high && in_soft),
        .done_out(ovp_ss_q));
    barc_qual_timer #(.LIMIT(T_OVP_HI)) u_ovphi (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff), .cond_in(vcc_ov_hi && !burst_ff && running),
        .done_out(ovp_hi_q));
    barc_qual_timer #(.LIMIT(T_SPIKE)) u_otp (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff), .cond_in(otp && running),
        .done_out(otp_q));
    barc_qual_timer #(.LIMIT(T_SPIKE)) u_ovlpin (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff),
        .cond_in(fb_high && pin_high && clamp_rel_ff && running),
        .done_out(ovl_pin_q));
    barc_qual_timer #(.LIMIT(T_UV)) u_uv (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff), .cond_in(vcc_uv && running),
        .done_out(uv_q));
    // restart request masked for a while after every start
    barc_qual_timer #(.LIMIT(T_MASK)) u_mask (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff), .cond_in(running),
        .done_out(mask_q));
    wire ext_req = pin_low && mask_q && ctrl_ff[`BARC_CTRL_RESTART_EN] && running;
    barc_qual_timer #(.LIMIT(T_SPIKE)) u_ext (.core_clk_in(core_clk_in),
        .rst_in(rst_in), .tick_in(tick_ff), .cond_in(ext_req),
        .done_out(ext_q));

    // only overload goes through the extended blanking path
    wire [`BARC_NCAUSE-1:0] faults = {ext_q, uv_q, ovl_pin_q, otp_q, ovp_hi_q,
        ovp_ss_q};
    wire any_fault = |faults;

    ////////////////////////////////////////////////////////////////////
    // burst mode control
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            burst_ff <= 1'b0;
            bias_en_out <= 1'b1;
        end else if (!running) begin
            burst_ff <= 1'b0;
            bias_en_out <= 1'b1;
        end else if (burst_ff && fb_high) begin
            burst_ff <= 1'b0;
            bias_en_out <= 1'b1;
        end else if (burst_ff && fb_wake) begin
            bias_en_out <= 1'b1;
        end else if (burst_ff && fb_sleep && bias_en_out) begin
            bias_en_out <= 1'b0;
        end else if (!burst_ff && burst_q && fb_low) begin
            burst_ff <= 1'b1;
            bias_en_out <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // auto restart sequence
    reg [`BARC_ST_W-1:0] nxt_state;
    always @* begin
        nxt_state = state_ff;
        case (state_ff)
            `BARC_S_RUN: if (any_fault) nxt_state = `BARC_S_OFF;
            `BARC_S_OFF: if (vcc_uv) nxt_state = `BARC_S_CHARGE;
            `BARC_S_CHARGE: if (vcc_on) nxt_state = `BARC_S_SOFT;
            `BARC_S_SOFT: begin
                if (any_fault) begin
                    nxt_state = `BARC_S_OFF;
                end else if (ss_done) begin
                    nxt_state = `BARC_S_RUN;
                end
            end
            default: nxt_state = `BARC_S_OFF;
        endcase
    end
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            state_ff <= `BARC_S_SOFT;
            cause_ff <= {`BARC_NCAUSE{1'b0}};
            clamp_rel_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            if (running && any_fault) begin
                cause_ff <= faults;
            end
            clamp_rel_ff <= ovl_q;
        end
    end

    // outputs to the power stage
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            reduced_limit_out <= 1'b0;
            gate_en_out <= 1'b0;
            pin_clamp_out <= 1'b1;
            startup_cell_out <= 1'b0;
            soft_start_out <= 1'b0;
        end else begin
            reduced_limit_out <= burst_ff && !(fb_high);
            gate_en_out <= running && !any_fault && !(pin_low && mask_q
                && ctrl_ff[`BARC_CTRL_RESTART_EN]) && !(burst_ff && !bias_en_out);
            pin_clamp_out <= !ovl_q;
            startup_cell_out <= (nxt_state == `BARC_S_CHARGE);
            soft_start_out <= (nxt_state == `BARC_S_SOFT);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // wishbone slave, ack one cycle after strobe
    function [31:0] rd_mux;
        input [`BARC_ADDR_W-1:0] a;
        begin
            case (a)
                `BARC_REG_CTRL: rd_mux = {30'h0, ctrl_ff};
                `BARC_REG_STATUS: rd_mux = {24'h0, gate_en_out, pin_clamp_out,
                    soft_start_out, startup_cell_out, !running, reduced_limit_out,
                    bias_en_out, burst_ff};
                `BARC_REG_CAUSE: rd_mux = {26'h0, cause_ff};
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always @(posedge core_clk_in) begin
        if (rst_in) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            ctrl_ff <= `BARC_CTRL_RST;
        end else begin
            wb_ack_o <= wb_req;
            if (wb_req) begin
                wb_dat_o <= rd_mux(wb_adr_i[`BARC_ADDR_W-1:0]);
                if (wb_we_i && wb_sel_i[0] && wb_adr_i[`BARC_ADDR_W-1:0] == `BARC_REG_CTRL) begin
                    ctrl_ff <= wb_dat_i[1:0];
                end
            end
        end
    end
endmodule
`default_nettype wire

// *** bench/barc_core_asserts.sv ***
// port checker for the burst and restart controller
`timescale 1ns/1ps
`default_nettype none
module barc_core_asserts (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic fb_below_1v35_in,
    input wire logic fb_above_4v0_in,
    input wire logic vcc_above_25v5_in,
    input wire logic vcc_below_10v5_in,
    input wire logic over_temp_in,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_ack_o,
    input wire logic bias_en_out,
    input wire logic reduced_limit_out,
    input wire logic gate_en_out,
    input wire logic pin_clamp_out,
    input wire logic startup_cell_out,
    input wire logic soft_start_out
);
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    logic [14:0] ot_cnt_ff;
    logic [14:0] ov_cnt_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // run lengths of held fault levels, worst case tick phase plus sync included
    always @(posedge core_clk_in) begin
        ot_cnt_ff <= (rst_in || !over_temp_in) ? 15'h0000 : ot_cnt_ff + 15'h0001;
        ov_cnt_ff <= (rst_in || !vcc_above_25v5_in) ? 15'h0000 : ov_cnt_ff + 15'h0001;
    end
    AST_RESET_OUT: assert property (disable iff (1'b0) rst_in |=>
        bias_en_out && !gate_en_out && !reduced_limit_out && pin_clamp_out
        && !startup_cell_out && !soft_start_out)
        else $error("outputs not at reset levels");
    AST_ACK_LATENCY: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus access not acknowledged next cycle");
    AST_ACK_PULSE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("acknowledge longer than one cycle");
    AST_CELL_GATE: assert property (startup_cell_out |-> !gate_en_out && !soft_start_out)
        else $error("switching while startup cell on");
    AST_CELL_CAUSE: assert property ($rose(startup_cell_out) |-> $past(vcc_below_10v5_in, 3))
        else $error("startup cell on without turn-off level");
    AST_CELL_SOFT: assert property ($fell(startup_cell_out) |-> ##[0:2] soft_start_out)
        else $error("no soft start after charging");
    AST_OTP_HELD: assert property (ot_cnt_ff == 15'h0F3C |-> !gate_en_out)
        else $error("overtemperature held 30 us without restart");
    AST_OVP_HELD: assert property (ov_cnt_ff == 15'h49D4 && !reduced_limit_out |-> !gate_en_out)
        else $error("supply overvoltage held 150 us without restart");
    AST_CLAMP_CAUSE: assert property ($fell(pin_clamp_out) |-> $past(fb_above_4v0_in, 4))
        else $error("clamp released without high feedback");
    AST_BURST_CAUSE: assert property ($rose(reduced_limit_out) |-> $past(fb_below_1v35_in, 4))
        else $error("burst entered without low feedback");
    // main scenarios reached
    cover property ($rose(startup_cell_out));
    cover property ($fell(soft_start_out) && gate_en_out);
    cover property (wb_ack_o);
endmodule
bind barc_core barc_core_asserts u_asserts (.core_clk_in, .rst_in, .fb_below_1v35_in,
    .fb_above_4v0_in, .vcc_above_25v5_in, .vcc_below_10v5_in, .over_temp_in, .wb_cyc_i,
    .wb_stb_i, .wb_ack_o, .bias_en_out, .reduced_limit_out, .gate_en_out, .pin_clamp_out,
    .startup_cell_out, .soft_start_out);
`default_nettype wire

// *** bench/barc_supply_model.sv ***
// supply rail and soft start stand-in on the far side of the controller
`timescale 1ns/1ps
`default_nettype none
module barc_supply_model #(
    parameter int SAG_CYC = 200,
    parameter int SOFT_CYC = 5000
) (
    input wire logic core_clk_in,
    input wire logic rst_in,
    input wire logic gate_en_in,
    input wire logic startup_cell_in,
    input wire logic soft_start_in,
    output logic vcc_below_10v5_out,
    output logic vcc_above_on_out,
    output logic soft_start_done_out
);
    logic [1:0] mode;
    logic [1:0] mode_ff;
    logic [15:0] cnt_ff;
    ////////////////////////////////////////////////////////////////////////////////
    // 2: cell charging, 1: no switching so the rail sags, 0: switching
    assign mode = startup_cell_in ? 2'h2 : (!gate_en_in && !soft_start_in) ? 2'h1 : 2'h0;
    // slow rail: levels move some time after the cause, except the turn-off level, which clears at once on charging
    always @(posedge core_clk_in) begin
        mode_ff <= mode;
        cnt_ff <= (rst_in || mode != mode_ff) ? 16'h0000 : cnt_ff + 16'h0001;
        if (rst_in) begin
            vcc_below_10v5_out <= 1'b0;
            vcc_above_on_out <= 1'b1;
            soft_start_done_out <= 1'b0;
        end else begin
            if (mode == 2'h1 && cnt_ff == 16'(SAG_CYC)) begin
                vcc_above_on_out <= 1'b0;
                vcc_below_10v5_out <= 1'b1;
            end
            if (mode == 2'h2) begin
                vcc_below_10v5_out <= 1'b0;
            end
            if (mode == 2'h2 && cnt_ff == 16'(SAG_CYC)) begin
                vcc_above_on_out <= 1'b1;
            end
            soft_start_done_out <= soft_start_in && (soft_start_done_out || cnt_ff == 16'(SOFT_CYC));
        end
    end
endmodule
`default_nettype wire

// *** bench/barc_core_bench.sv ***
// self-checking bench of the burst and restart controller
`timescale 1ns/1ps
`default_nettype none
module barc_core_bench;
    logic core_clk_in, rst_in, fb_below_1v35_in, fb_above_4v0_in, vcc_above_20v5_in;
    logic vcc_above_25v5_in, over_temp_in, pin_below_0v33_in, wb_we_i, wb_cyc_i, wb_stb_i;
    logic wb_ack_o, bias_en_out, reduced_limit_out, gate_en_out, pin_clamp_out;
    logic startup_cell_out, soft_start_out, vcc_below_10v5_in, vcc_above_on_in;
    logic soft_start_done_in, fb_above_3v5_in, fb_below_3v0_in, pin_above_4v0_in;
    logic [31:0] wb_adr_i, wb_dat_i, wb_dat_o, rd;
    int err_count, checked, n;
    ////////////////////////////////////////////////////////////////////////////////
    barc_core dut (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .fb_below_1v35_in(fb_below_1v35_in), .fb_above_3v5_in(fb_above_3v5_in),
        .fb_below_3v0_in(fb_below_3v0_in),
        .fb_above_4v0_in(fb_above_4v0_in), .vcc_above_20v5_in(vcc_above_20v5_in),
        .vcc_above_25v5_in(vcc_above_25v5_in), .vcc_below_10v5_in(vcc_below_10v5_in),
        .vcc_above_on_in(vcc_above_on_in), .over_temp_in(over_temp_in),
        .pin_above_4v0_in(pin_above_4v0_in), .pin_below_0v33_in(pin_below_0v33_in),
        .soft_start_done_in(soft_start_done_in), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(4'hF), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .bias_en_out(bias_en_out),
        .reduced_limit_out(reduced_limit_out), .gate_en_out(gate_en_out),
        .pin_clamp_out(pin_clamp_out), .startup_cell_out(startup_cell_out),
        .soft_start_out(soft_start_out));
    barc_supply_model u_supply (.core_clk_in(core_clk_in), .rst_in(rst_in),
        .gate_en_in(gate_en_out), .startup_cell_in(startup_cell_out),
        .soft_start_in(soft_start_out), .vcc_below_10v5_out(vcc_below_10v5_in),
        .vcc_above_on_out(vcc_above_on_in), .soft_start_done_out(soft_start_done_in));
    // compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one classic bus cycle, entered just after a rising edge
    task automatic wb(input logic [31:0] a, input logic w, input logic [31:0] d);
        int k;
        k = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_dat_i <= d;
        do begin
            @(posedge core_clk_in);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 20);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        chk({31'h0, wb_ack_o}, 32'h1);
        @(posedge core_clk_in);
    endtask
    // wait for {gate, soft start, cell} under mask m, bounded
    task automatic wait_st(input logic [2:0] m, input logic [2:0] st);
        n = 0;
        while (({gate_en_out, soft_start_out, startup_cell_out} & m) !== st && n < 30000) begin
            @(posedge core_clk_in);
            n++;
        end
        chk({29'h0, gate_en_out, soft_start_out, startup_cell_out} & m, {29'h0, st});
    endtask
    task automatic t_regs();
        chk({28'h0, bias_en_out, reduced_limit_out, pin_clamp_out, startup_cell_out}, 32'hA);
        wb(32'h0, 1'b0, 32'h0);
        chk(rd, 32'h3);
        wb(32'h0, 1'b1, 32'h0);
        wb(32'h0, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wb(32'h0, 1'b1, 32'h3);
        wb(32'hC, 1'b1, 32'hFFFFFFFF);
        wb(32'hC, 1'b0, 32'h0);
        chk(rd, 32'h0);
        wait_st(3'h7, 3'h4);
        wb(32'h4, 1'b0, 32'h0);
        chk(rd & 32'hFF, 32'hC2);
    endtask
    task automatic t_otp();
        over_temp_in <= 1'b1;
        repeat (3125) @(posedge core_clk_in);
        over_temp_in <= 1'b0;
        repeat (125) @(posedge core_clk_in);
        over_temp_in <= 1'b1;
        repeat (3500) @(posedge core_clk_in);
        chk({31'h0, gate_en_out}, 32'h1);
        repeat (500) @(posedge core_clk_in);
        chk({31'h0, gate_en_out}, 32'h0);
        wb(32'h8, 1'b0, 32'h0);
        chk(rd & 32'h4, 32'h4);
        wait_st(3'h7, 3'h1);
        wait_st(3'h2, 3'h2);
        wait_st(3'h7, 3'h0);
        over_temp_in <= 1'b0;
    endtask
    task automatic t_ovp_soft();
        wait_st(3'h2, 3'h2);
        vcc_above_20v5_in <= 1'b1;
        fb_above_4v0_in <= 1'b1;
        repeat (4000) @(posedge core_clk_in);
        vcc_above_20v5_in <= 1'b0;
        fb_above_4v0_in <= 1'b0;
        wait_st(3'h7, 3'h1);
        wb(32'h8, 1'b0, 32'h0);
        chk(rd & 32'h1, 32'h1);
    endtask
    task automatic t_mask();
        wait_st(3'h2, 3'h2);
        pin_below_0v33_in <= 1'b1;
        repeat (6250) @(posedge core_clk_in);
        pin_below_0v33_in <= 1'b0;
        wait_st(3'h7, 3'h4);
        wb(32'h8, 1'b0, 32'h0);
        chk(rd & 32'h21, 32'h1);
    endtask
    task automatic t_ovp_hi();
        vcc_above_25v5_in <= 1'b1;
        repeat (17500) @(posedge core_clk_in);
        chk({31'h0, gate_en_out}, 32'h1);
        repeat (1500) @(posedge core_clk_in);
        chk({31'h0, gate_en_out}, 32'h0);
        vcc_above_25v5_in <= 1'b0;
        wb(32'h8, 1'b0, 32'h0);
        chk(rd & 32'h2, 32'h2);
        wait_st(3'h7, 3'h4);
    endtask
    task automatic t_burst_glitch();
        fb_below_1v35_in <= 1'b1;
        fb_below_3v0_in <= 1'b1;
        repeat (12500) @(posedge core_clk_in);
        chk({31'h0, bias_en_out}, 32'h1);
        fb_below_1v35_in <= 1'b0;
        fb_below_3v0_in <= 1'b0;
        repeat (10) @(posedge core_clk_in);
        chk({30'h0, reduced_limit_out, bias_en_out}, 32'h1);
        wb(32'h4, 1'b0, 32'h0);
        chk(rd & 32'h1, 32'h0);
        // high feedback and high pin level while the clamp still holds: no restart
        fb_above_3v5_in <= 1'b1;
        fb_above_4v0_in <= 1'b1;
        pin_above_4v0_in <= 1'b1;
        repeat (6250) @(posedge core_clk_in);
        chk({29'h0, bias_en_out, gate_en_out, pin_clamp_out}, 32'h7);
        fb_above_3v5_in <= 1'b0;
        fb_above_4v0_in <= 1'b0;
        pin_above_4v0_in <= 1'b0;
    endtask
    task automatic results();
        $display("checks %0d errors %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // clock
    initial begin
        core_clk_in = 1'b0;
        forever #4 core_clk_in = ~core_clk_in;
    end
    // watchdog
    initial begin
        repeat (90000) @(posedge core_clk_in);
        err_count++;
        results();
    end
    // main sequence
    initial begin
        {err_count, checked} = '0;
        {rst_in, fb_below_1v35_in, fb_above_4v0_in, vcc_above_20v5_in} = 4'h8;
        {vcc_above_25v5_in, over_temp_in, pin_below_0v33_in, wb_we_i} = 4'h0;
        {fb_above_3v5_in, fb_below_3v0_in, pin_above_4v0_in} = 3'h0;
        {wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        repeat (2) @(posedge core_clk_in);
        t_regs();
        t_otp();
        t_ovp_soft();
        t_mask();
        t_ovp_hi();
        t_burst_glitch();
        results();
    end
endmodule
`default_nettype wire
